// file: rtl/alfc_pkg.sv
// Package with register map, field layouts and types of the list flow control.
// How it works
// - Result resolution is selectable as 8, 10 or 12 bits.
// - Command list holds up to 64 entries, run in order from the top.
// - Fifteen assignable conversion flags plus one end-of-list flag.
// - Command and result lists each have an active and an alternative buffer.
// - Command entries are fetched from RAM or from non-volatile memory.
// - Results are stored left or right justified, as configured.
// - Four option bits of each command are passed to the chip top.
// - Restart and trigger flow modes; flow register on a selectable path.
// - Error enable bits 7,6,5,3,2,1 gate their error interrupts.
// - Flag select zero sets nothing; value n sets only flag n.
// - Trigger mode restarts from idle with an internal trigger.
// - Restart and abort in one write: abort first, then restart.
// - Restart with abort hides restart error; restart mode hides load-ok too.
// - Same suppression when restart, load-ok and abort share one write.
// - Restart while busy without abort aborts itself and flags an error.
// - Load-ok given with the restart swaps active and alternative buffers.
// - Abort bit clears itself once aborted; cleared means idle.
// - After abort, restart with load-ok, then run from new list top.
package alfc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_FLOW     = 4'h0;
  localparam logic [3:0] IDX_CFG      = 4'h1;
  localparam logic [3:0] IDX_FLOW_ALT = 4'h2;
  localparam logic [3:0] IDX_STATUS   = 4'h3;
  localparam logic [3:0] IDX_ERRFLAG  = 4'h4;
  localparam logic [3:0] IDX_CONVIF   = 4'h5;
  localparam logic [3:0] IDX_EIE      = 4'h6;
  localparam logic [3:0] IDX_CSL0     = 4'h7;
  localparam logic [3:0] IDX_CSL1     = 4'h8;
  localparam logic [3:0] IDX_RES0     = 4'h9;
  localparam logic [3:0] IDX_RES1     = 4'hA;

  // Flow control bit positions.
  localparam int FLOW_TRIGGER_REQUEST = 0;
  localparam int FLOW_RESTART_REQUEST = 1;
  localparam int FLOW_LIST_SWAP_OK = 2;
  localparam int FLOW_SEQUENCE_ABORT = 3;

  // Error flag and enable bit positions.
  localparam int ERR_IA   = 7;
  localparam int ERR_CMD  = 6;
  localparam int ERR_EOL  = 5;
  localparam int ERR_TRIGGER_REQUEST = 3;
  localparam int ERR_RSTR = 2;
  localparam int ERR_LIST_SWAP_OK = 1;
  localparam int ERR_RESTART_REQUEST = 0;

  // Reset values.
  localparam logic [7:0]  EIE_RESET  = 8'h00;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [15:0] BASE_RESET = 16'h0000;

  // List size and encodings.
  localparam logic [5:0] LIST_LAST = 6'h3F;
  localparam logic [1:0] RES_8  = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_12 = 2'h2;
  localparam logic [1:0] CT_NORMAL = 2'h0;
  localparam logic [1:0] CT_EOS    = 2'h1;
  localparam logic [1:0] CT_EOL    = 2'h2;

  // Conversion command word as fetched from memory.
  typedef struct packed {
    logic [15:0] spare;
    logic [5:0]  chan;
    logic [3:0]  opt;
    logic [3:0]  fsel;
    logic [1:0]  ctype;
  } alfc_cmd_t;

  // Configuration register layout.
  typedef struct packed {
    logic [1:0] spare;
    logic       path_alt;
    logic       nvm_src;
    logic       left_just;
    logic [1:0] res;
    logic       restart_mode;
  } alfc_cfg_t;

  // Memory request and answer.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        nvm;
    logic [15:0] addr;
    logic [15:0] wdata;
  } alfc_mreq_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } alfc_mrsp_t;

  // Command to the analog converter.
  typedef struct packed {
    logic       start;
    logic [5:0] chan;
    logic [1:0] res;
    logic [3:0] opt;
  } alfc_conv_t;

endpackage : alfc_pkg

// file: rtl/alfc_flag_decode.sv
// One-hot decoder from a command flag select to the conversion flags.
`timescale 1ns/1ps
module alfc_flag_decode
  import alfc_pkg::*;
(
  // Select and decoded flags
  input  wire logic [3:0]  sel,
  output logic      [15:1] onehot
);

  // Each flag compares the select with its own number; zero matches none.
  genvar g;
  for (g = 1; g < 16; g++) begin : g_flag
    assign onehot[g] = (sel == 4'(g));
  end

endmodule : alfc_flag_decode

// file: rtl/alfc_justify.sv
// Places a raw converter sample into a 16-bit result word.
`timescale 1ns/1ps
module alfc_justify
  import alfc_pkg::*;
(
  // Sample, format and result
  input  wire logic [11:0] raw,
  input  wire logic [1:0]  res,
  input  wire logic        left_just,
  output logic      [15:0] result
);

  // The sample is MSB aligned, so lower resolutions drop its low bits.
  always_comb begin
    case (res)
      RES_8:   result = left_just ? {raw[11:4], 8'h00}
                                  : {8'h00, raw[11:4]};
      RES_10:  result = left_just ? {raw[11:2], 6'h00}
                                  : {6'h00, raw[11:2]};
      default: result = left_just ? {raw, 4'h0}
                                  : {4'h0, raw};
    endcase
  end

endmodule : alfc_justify

// file: rtl/alfc_top.sv
// List flow control of the converter with its APB register file.
`timescale 1ns/1ps
module alfc_top
  import alfc_pkg::*;
#(
  parameter int APB_AW = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // List memory port
  output alfc_mreq_t             mem_req,
  input  wire alfc_mrsp_t        mem_rsp,
  // Converter port
  output alfc_conv_t             conv_cmd,
  input  wire logic              conv_done,
  input  wire logic [11:0]       conv_data,
  // Interrupt lines
  output logic                   err_irq,
  output logic      [15:1]       conv_irq,
  output logic                   eol_irq
);

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_CONV, ST_STORE}
    alfc_state_t;

  //////////////////////////////////////////////////////////////////////////
  // State
  alfc_state_t state_reg;
  alfc_cfg_t   cfg_reg;
  alfc_cmd_t   cmd_reg;
  alfc_mreq_t  mreq_reg;
  alfc_conv_t  conv_reg;
  logic [7:0]  eie_reg;
  logic [7:0]  err_reg;
  logic [15:1] cif_reg;
  logic        eol_reg;
  logic [15:0] csl_base_reg [2];
  logic [15:0] res_base_reg [2];
  logic        trigger_request_reg;
  logic        restart_request_reg;
  logic        list_swap_ok_reg;
  logic        sequence_abort_reg;
  logic        armed_reg;
  logic        act_reg;
  logic [5:0]  cmd_idx_reg;
  logic [5:0]  res_idx_reg;
  logic [15:0] result_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        err_irq_reg;
  logic [15:1] conv_irq_reg;
  logic        eol_irq_reg;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [3:0]  idx;
  logic        hi_zero;
  logic        access;
  logic        wr_en;
  logic        mapped;
  logic        ro_hit;
  logic        flow_hit;
  logic        flow_wr;
  logic [31:0] rd_mux;

  assign idx     = paddr[5:2];
  assign hi_zero = (paddr[APB_AW-1:6] == '0);
  assign access  = psel && penable && pready_reg;
  assign wr_en   = access && pwrite && mapped;
  assign ro_hit  = (idx == IDX_STATUS);

  // Only the flow register on the selected path answers.
  assign flow_hit = cfg_reg.path_alt ? (idx == IDX_FLOW_ALT)
                                     : (idx == IDX_FLOW);
  assign mapped = hi_zero && (flow_hit || (idx == IDX_CFG) ||
                  (idx == IDX_STATUS) || (idx == IDX_ERRFLAG) ||
                  (idx == IDX_CONVIF) || (idx == IDX_EIE) ||
                  (idx == IDX_CSL0) || (idx == IDX_CSL1) ||
                  (idx == IDX_RES0) || (idx == IDX_RES1));
  assign flow_wr = wr_en && flow_hit;

  // Read multiplexer; unused bits read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hi_zero && flow_hit) begin
      rd_mux[FLOW_TRIGGER_REQUEST] = trigger_request_reg;
      rd_mux[FLOW_RESTART_REQUEST] = restart_request_reg;
      rd_mux[FLOW_LIST_SWAP_OK] = list_swap_ok_reg;
      rd_mux[FLOW_SEQUENCE_ABORT] = sequence_abort_reg;
    end else if (hi_zero) begin
      case (idx)
        IDX_CFG:     rd_mux[7:0]   = cfg_reg;
        IDX_STATUS:  rd_mux[15:0]  = {res_idx_reg, cmd_idx_reg,
                                      armed_reg, act_reg,
                                      (state_reg != ST_IDLE), 1'b0};
        IDX_ERRFLAG: rd_mux[7:0]   = err_reg;
        IDX_CONVIF:  rd_mux[15:0]  = {cif_reg, eol_reg};
        IDX_EIE:     rd_mux[7:0]   = eie_reg;
        IDX_CSL0:    rd_mux[15:0]  = csl_base_reg[0];
        IDX_CSL1:    rd_mux[15:0]  = csl_base_reg[1];
        IDX_RES0:    rd_mux[15:0]  = res_base_reg[0];
        IDX_RES1:    rd_mux[15:0]  = res_base_reg[1];
        default:     rd_mux        = 32'h0000_0000;
      endcase
    end
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg &&
                     (!mapped || (pwrite && ro_hit));
      if (psel && penable && !pready_reg && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // Plain read-write registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg         <= CFG_RESET;
      eie_reg         <= EIE_RESET;
      csl_base_reg[0] <= BASE_RESET;
      csl_base_reg[1] <= BASE_RESET;
      res_base_reg[0] <= BASE_RESET;
      res_base_reg[1] <= BASE_RESET;
    end else if (wr_en && !flow_hit) begin
      case (idx)
        IDX_CFG:  cfg_reg         <= pwdata[7:0];
        IDX_EIE:  eie_reg         <= pwdata[7:0];
        IDX_CSL0: csl_base_reg[0] <= pwdata[15:0];
        IDX_CSL1: csl_base_reg[1] <= pwdata[15:0];
        IDX_RES0: res_base_reg[0] <= pwdata[15:0];
        IDX_RES1: res_base_reg[1] <= pwdata[15:0];
        default:  cfg_reg         <= cfg_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flow control events
  logic busy;
  logic w_trigger_request;
  logic w_restart_request;
  logic w_list_swap_ok;
  logic w_sequence_abort;
  logic auto_abort;
  logic abort_done;
  logic restart_go;
  logic start_go;
  logic trigger_request_err;
  logic restart_request_err;
  logic list_swap_ok_err;
  logic store_done;
  logic fetch_done;
  logic cmd_bad;
  logic [15:1] flag_hot;
  logic [15:0] justified;

  assign busy   = (state_reg != ST_IDLE);
  assign w_trigger_request = flow_wr && pwdata[FLOW_TRIGGER_REQUEST];
  assign w_restart_request = flow_wr && pwdata[FLOW_RESTART_REQUEST];
  assign w_list_swap_ok = flow_wr && pwdata[FLOW_LIST_SWAP_OK];
  assign w_sequence_abort = flow_wr && pwdata[FLOW_SEQUENCE_ABORT];

  // A busy restart with no abort under way aborts by itself.
  assign auto_abort = w_restart_request && busy && !sequence_abort_reg && !w_sequence_abort;
  // A restart over a running or pending sequence; hidden with abort.
  assign restart_request_err = w_restart_request && (busy || restart_request_reg) && !auto_abort &&
                    !w_sequence_abort;
  // Load-ok without restart or over a busy list; restart with abort in restart mode hides it.
  assign list_swap_ok_err = w_list_swap_ok && (!w_restart_request || busy) &&
                    !(w_sequence_abort && w_restart_request && cfg_reg.restart_mode);
  // A trigger is refused while running or when no list is armed.
  assign trigger_request_err = w_trigger_request && (busy || !armed_reg || restart_request_reg);
  // Abort waits for an outstanding memory access before ending.
  assign abort_done = sequence_abort_reg &&
                      (!mreq_reg.valid || mem_rsp.ack);
  // Restart runs only after any abort, so abort always goes first.
  assign restart_go = !busy && restart_request_reg && !sequence_abort_reg;
  assign start_go   = !busy && armed_reg && trigger_request_reg && !restart_request_reg &&
                      !sequence_abort_reg;
  assign fetch_done = (state_reg == ST_FETCH) && mreq_reg.valid &&
                      mem_rsp.ack && !sequence_abort_reg;
  assign cmd_bad    = !(mem_rsp.rdata[1:0] inside {CT_NORMAL, CT_EOS,
                                                   CT_EOL});
  assign store_done = (state_reg == ST_STORE) && mreq_reg.valid &&
                      mem_rsp.ack;

  // Flow bits: software sets, the sequencer clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_request_reg <= 1'b0;
      restart_request_reg <= 1'b0;
      list_swap_ok_reg <= 1'b0;
      sequence_abort_reg <= 1'b0;
    end else begin
      if (w_trigger_request && !trigger_request_err) begin
        trigger_request_reg <= 1'b1;
      end else if (start_go) begin
        trigger_request_reg <= 1'b0;
      end
      if (w_restart_request) begin
        restart_request_reg <= 1'b1;
      end else if (restart_go) begin
        restart_request_reg <= 1'b0;
      end
      if (w_list_swap_ok) begin
        list_swap_ok_reg <= 1'b1;
      end else if (restart_go) begin
        list_swap_ok_reg <= 1'b0;
      end
      if ((w_sequence_abort && busy) || auto_abort) begin
        sequence_abort_reg <= 1'b1;
      end else if (abort_done || !busy) begin
        sequence_abort_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_IDLE;
      cmd_reg     <= '0;
      mreq_reg    <= '0;
      conv_reg    <= '0;
      armed_reg   <= 1'b0;
      act_reg     <= 1'b0;
      cmd_idx_reg <= 6'h00;
      res_idx_reg <= 6'h00;
      result_reg  <= 16'h0000;
    end else begin
      conv_reg.start <= 1'b0;
      if (mem_rsp.ack) begin
        mreq_reg.valid <= 1'b0;
      end
      if (abort_done && busy) begin
        state_reg <= ST_IDLE;
        armed_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (restart_go) begin
              cmd_idx_reg <= 6'h00;
              res_idx_reg <= 6'h00;
              if (list_swap_ok_reg) begin
                act_reg <= !act_reg;
              end
              // Trigger mode supplies its own trigger.
              if (cfg_reg.restart_mode) begin
                armed_reg <= 1'b1;
              end else begin
                state_reg <= ST_FETCH;
              end
            end else if (start_go) begin
              armed_reg <= 1'b0;
              state_reg <= ST_FETCH;
            end
          end
          ST_FETCH: begin
            if (!mreq_reg.valid && !sequence_abort_reg) begin
              mreq_reg.valid <= 1'b1;
              mreq_reg.write <= 1'b0;
              mreq_reg.nvm   <= cfg_reg.nvm_src;
              mreq_reg.addr  <= csl_base_reg[act_reg] +
                                {8'h00, cmd_idx_reg, 2'b00};
            end else if (fetch_done) begin
              if (cmd_bad) begin
                state_reg <= ST_IDLE;
              end else begin
                cmd_reg        <= mem_rsp.rdata;
                conv_reg.start <= 1'b1;
                conv_reg.chan  <= mem_rsp.rdata[15:10];
                conv_reg.opt   <= mem_rsp.rdata[9:6];
                conv_reg.res   <= cfg_reg.res;
                state_reg      <= ST_CONV;
              end
            end
          end
          ST_CONV: begin
            if (conv_done) begin
              result_reg     <= justified;
              mreq_reg.valid <= 1'b1;
              mreq_reg.write <= 1'b1;
              mreq_reg.nvm   <= 1'b0;
              mreq_reg.addr  <= res_base_reg[act_reg] +
                                {9'h000, res_idx_reg, 1'b0};
              mreq_reg.wdata <= justified;
              state_reg      <= ST_STORE;
            end
          end
          ST_STORE: begin
            if (store_done) begin
              res_idx_reg <= res_idx_reg + 6'h01;
              cmd_idx_reg <= cmd_idx_reg + 6'h01;
              case (cmd_reg.ctype)
                CT_EOS: begin
                  armed_reg <= 1'b1;
                  state_reg <= ST_IDLE;
                end
                CT_EOL: begin
                  cmd_idx_reg <= 6'h00;
                  res_idx_reg <= 6'h00;
                  armed_reg   <= 1'b1;
                  state_reg   <= ST_IDLE;
                end
                default: begin
                  // No end-of-list within the entries ends the run.
                  state_reg <= (cmd_idx_reg == LIST_LAST) ? ST_IDLE
                                                          : ST_FETCH;
                end
              endcase
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  alfc_justify u_justify (
    .raw       (conv_data),
    .res       (cfg_reg.res),
    .left_just (cfg_reg.left_just),
    .result    (justified)
  );

  alfc_flag_decode u_flag_decode (
    .sel    (cmd_reg.fsel),
    .onehot (flag_hot)
  );

  //////////////////////////////////////////////////////////////////////////
  // Flags; a hardware set wins over a write-one clear.
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic       list_overrun;

  assign list_overrun = store_done && (cmd_reg.ctype == CT_NORMAL) &&
                        (cmd_idx_reg == LIST_LAST);
  always_comb begin
    err_set           = 8'h00;
    err_set[ERR_IA]   = access && (!mapped || (pwrite && ro_hit));
    err_set[ERR_CMD]  = fetch_done && cmd_bad;
    err_set[ERR_EOL]  = list_overrun;
    err_set[ERR_TRIGGER_REQUEST] = trigger_request_err;
    err_set[ERR_RSTR] = auto_abort;
    err_set[ERR_LIST_SWAP_OK] = list_swap_ok_err;
    err_set[ERR_RESTART_REQUEST] = restart_request_err;
  end
  assign err_clr = (wr_en && idx == IDX_ERRFLAG && !flow_hit) ?
                   pwdata[7:0] : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 8'h00;
    end else begin
      err_reg <= (err_reg & ~err_clr) | err_set;
    end
  end

  // Conversion flags and end-of-list flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif_reg <= 15'h0000;
      eol_reg <= 1'b0;
    end else begin
      if (wr_en && idx == IDX_CONVIF && !flow_hit) begin
        cif_reg <= (cif_reg & ~pwdata[15:1]) |
                   (store_done ? flag_hot : 15'h0000);
        eol_reg <= (eol_reg && !pwdata[0]) ||
                   (store_done && cmd_reg.ctype == CT_EOL);
      end else if (store_done) begin
        cif_reg <= cif_reg | flag_hot;
        eol_reg <= eol_reg || (cmd_reg.ctype == CT_EOL);
      end
    end
  end

  // Interrupt lines; restart request error shares the restart error enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_irq_reg  <= 1'b0;
      conv_irq_reg <= 15'h0000;
      eol_irq_reg  <= 1'b0;
    end else begin
      err_irq_reg  <= |(err_reg[7:1] & eie_reg[7:1]) ||
                      (err_reg[ERR_RESTART_REQUEST] && eie_reg[ERR_RSTR]);
      conv_irq_reg <= cif_reg;
      eol_irq_reg  <= eol_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready   = pready_reg;
  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;
  assign mem_req  = mreq_reg;
  assign conv_cmd = conv_reg;
  assign err_irq  = err_irq_reg;
  assign conv_irq = conv_irq_reg;
  assign eol_irq  = eol_irq_reg;

endmodule : alfc_top

// file: sim/alfc_properties.sv
// Port timing checker for the list flow control block.
`timescale 1ns/1ps
module alfc_properties
  import alfc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus and list memory
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire alfc_mreq_t  mem_req,
  input wire alfc_mrsp_t  mem_rsp,
  // Converter and interrupts
  input wire alfc_conv_t  conv_cmd,
  input wire logic        conv_done,
  input wire logic        err_irq,
  input wire logic        eol_irq,
  input wire logic [15:1] conv_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // One wait state, then a single-cycle answer.
  a_pready_wait: assert property ($rose(psel && penable) |->
    !pready ##1 pready) else $error("late pready");
  a_pready_once: assert property (pready |=> !pready)
    else $error("pready too long");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  // A list access stands until answered and ends right after.
  a_mem_hold: assert property (mem_req.valid && !mem_rsp.ack |=>
    $stable(mem_req)) else $error("request moved");
  a_mem_drop: assert property (mem_req.valid && mem_rsp.ack |=>
    !mem_req.valid) else $error("request kept");
  // Starts are single pulses and never overlap list traffic.
  a_start_pulse: assert property (conv_cmd.start |=> !conv_cmd.start)
    else $error("long start");
  a_start_quiet: assert property (conv_cmd.start |->
    !mem_req.valid) else $error("start during access");
  a_done_store: assert property (conv_done |=>
    mem_req.valid && mem_req.write) else $error("no result store");
  a_reset_quiet: assert property ($rose(presetn) |-> !err_irq &&
    !eol_irq && conv_irq == '0) else $error("output after reset");
endmodule : alfc_properties

// file: sim/alfc_mem_model.sv
// Memory holding command lists and catching stored results.
`timescale 1ns/1ps
module alfc_mem_model
  import alfc_pkg::*;
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Request, answer and latency
  input wire alfc_mreq_t mem_req,
  output alfc_mrsp_t     mem_rsp,
  input wire logic [3:0] lag
);
  logic [31:0] store [logic [15:0]];
  logic [3:0]  wait_reg;
  logic        nvm_seen;  // Source flag of the last command fetch.
  // Answers after lag cycles; idle read data is inverted junk so that a
  // late capture of stale data cannot pass.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rsp <= '0;
      wait_reg <= '0;
    end else if (mem_rsp.ack || !mem_req.valid) begin
      mem_rsp <= {1'b0, ~mem_rsp.rdata};
      wait_reg <= '0;
    end else if (wait_reg < lag) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      mem_rsp.ack <= 1'b1;
      if (mem_req.write) store[mem_req.addr] = {16'h0, mem_req.wdata};
      else mem_rsp.rdata <= store[mem_req.addr];
      if (!mem_req.write) nvm_seen <= mem_req.nvm;
    end
  end
endmodule : alfc_mem_model

// file: sim/tb_adc_list_flow_control.sv
// Self-checking bench of the list flow control block.
`timescale 1ns/1ps
module tb_adc_list_flow_control;
  import alfc_pkg::*;
  // Bus, converter and bench state
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic conv_done = 0, hold = 0, pready, pslverr, err_irq, eol_irq, sl;
  logic [7:0] paddr = '0;
  logic [3:0] lag = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:1] conv_irq;
  alfc_mreq_t mem_req;
  alfc_mrsp_t mem_rsp;
  alfc_conv_t conv_cmd, last;
  int n_fail = 0, samples_checked = 0, cyc = 0, starts = 0;

  alfc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .conv_cmd(conv_cmd),
    .conv_done(conv_done), .conv_data(12'hABC), .err_irq(err_irq),
    .conv_irq(conv_irq), .eol_irq(eol_irq));
  alfc_mem_model mem_u (.pclk(pclk), .presetn(presetn),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .lag(lag));

  always #25 pclk = ~pclk;
  ////////////////////////////////////////
  // Converter: a sample follows each start unless held.
  always @(posedge pclk) begin
    conv_done <= 0;
    if (conv_cmd.start) begin
      last = conv_cmd;
      starts++;
      if (!hold) begin
        repeat (3) @(posedge pclk);
        conv_done <= 1;
      end
    end
  end
  // Cut a hung run short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; read data and error land in rd and sl.
  task automatic apb(logic w, logic [3:0] idx, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b0, idx, 2'b0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    rd = prdata;
    sl = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic idle;
    rd = '1;
    for (int i = 0; i < 99 && rd[1] !== 0; i++) apb(0, IDX_STATUS, 0);
    chk(rd[1], 0);
  endtask : idle

  task automatic regs;
    apb(0, IDX_EIE, 0);
    chk(rd, {24'h0, EIE_RESET});
    apb(1, IDX_EIE, 32'hEE);
    apb(0, IDX_EIE, 0);
    chk(rd, 32'hEE);
    apb(0, 4'hF, 0);
    chk(sl, 1);
    repeat (2) @(posedge pclk);
    chk(err_irq, 1);
    apb(1, IDX_EIE, 32'h6E);
    repeat (2) @(posedge pclk);
    chk(err_irq, 0);
    // A trigger with no armed list is refused and flags a trigger error.
    apb(1, IDX_FLOW, 32'h1);
    repeat (2) @(posedge pclk);
    chk(err_irq, 1);
  endtask : regs

  // A two-entry list in one configuration; latency varies with it.
  task automatic run(logic [7:0] cfg, logic [15:0] res);
    logic [3:0] f;
    f = cfg[5] ? IDX_FLOW_ALT : IDX_FLOW;
    starts = 0;
    lag <= cfg[3:0];
    mem_u.store.delete(16'h200);
    mem_u.store.delete(16'h202);
    apb(1, IDX_CONVIF, 32'hFFFF);
    apb(1, IDX_CFG, {24'h0, cfg});
    apb(1, cfg[5] ? IDX_FLOW : IDX_FLOW_ALT, 32'h2);
    chk(sl, 1);
    apb(1, f, 32'h2);
    if (cfg[0]) begin
      repeat (9) @(posedge pclk);
      chk(starts, 0);
      apb(1, f, 32'h1);
    end
    idle();
    chk(starts, 2);
    chk({last.chan, last.opt, last.res}, {6'h6, 4'h5, cfg[2:1]});
    chk(mem_u.store[16'h200], {16'h0, res});
    chk(mem_u.store[16'h202], {16'h0, res});
    chk(mem_u.nvm_seen, cfg[4]);
    chk({conv_irq, eol_irq}, 16'h0009);
  endtask : run

  task automatic aborts;
    int s;
    hold <= 1;
    apb(1, IDX_CFG, 0);
    apb(1, IDX_FLOW, 32'h2);
    repeat (9) @(posedge pclk);
    apb(1, IDX_ERRFLAG, 32'hFF);
    apb(1, IDX_FLOW, 32'h2);
    apb(0, IDX_ERRFLAG, 0);
    chk(rd[2:0], 3'h4);
    repeat (20) @(posedge pclk);
    s = starts;
    apb(1, IDX_ERRFLAG, 32'hFF);
    apb(1, IDX_FLOW, 32'hE);
    apb(0, IDX_ERRFLAG, 0);
    chk(rd[1:0], 2'h2);
    repeat (20) @(posedge pclk);
    chk(starts, s + 1);
    apb(1, IDX_CFG, 32'h1);
    apb(0, IDX_STATUS, 0);
    s = rd[2];
    apb(1, IDX_ERRFLAG, 32'hFF);
    apb(1, IDX_FLOW, 32'hE);
    apb(0, IDX_ERRFLAG, 0);
    chk(rd[1:0], 2'h0);
    apb(0, IDX_STATUS, 0);
    chk(rd[2], !s[0]);
    apb(1, IDX_FLOW, 32'h8);
    apb(0, IDX_FLOW, 0);
    chk(rd[3], 0);
    idle();
    hold <= 0;
  endtask : aborts

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // Main sequence: reset, list setup, then every scenario.
  initial begin
    mem_u.store[16'h100] = alfc_cmd_t'{16'h0, 6'h5, 4'hA, 4'h3, CT_NORMAL};
    mem_u.store[16'h104] = alfc_cmd_t'{16'h0, 6'h6, 4'h5, 4'h0, CT_EOL};
    repeat (6) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 4; i++)
      apb(1, 4'(IDX_CSL0 + i), i < 2 ? 32'h0100 : 32'h0200);
    regs();
    run(8'h14, 16'h0ABC);
    run(8'h0D, 16'hABC0);
    run(8'h22, 16'h02AF);
    run(8'h00, 16'h00AB);
    aborts();
    wrap_up();
  end
endmodule : tb_adc_list_flow_control

bind alfc_top alfc_properties chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_rsp(mem_rsp), .conv_cmd(conv_cmd),
  .conv_done(conv_done), .err_irq(err_irq), .eol_irq(eol_irq),
  .conv_irq(conv_irq));
